// [hdl/twe_cmd_port.sv]
// Command decoder, write-enable latch, program timer and serial output.
// Assumes serial pins arrive asynchronously and are oversampled by CLOCK.
`default_nettype none

// What this block does
// - Two opcode bits then address field shift in
// - Opcode 10 reads; field width follows variant
// - Read data change on serial clock rise
// - Dummy zero out during last address bit
// - Prefix 11 of opcode 00 sets enable
// - Enable latch clear after reset; writes ignored
// - Enable latch persists until disable or reset
// - Prefix 00 clears enable; array untouched
// - Opcode 11 erases location to ones
// - Program cycle ends back in standby
// - Opcode 01 takes 8 or 16 data bits
// - Program starts after last data bit
// - Prefix 10 erases whole array
// - Prefix 01 writes one word everywhere
// - Reads work whatever the enable latch
// - Status low while busy, high when done
// - No status once back in standby
// - Two-kilobit part ignores top address bit
// - One-kilobit part uses shorter address field
module twe_cmd_port #(
	parameter int unsigned PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic CLOCK,
	input  wire logic SYS_RST,
	// Serial link from the host
	input  wire logic CHIP_SELECT,
	input  wire logic SERIAL_CLOCK_IN,
	input  wire logic SERIAL_DATA_IN,
	input  wire logic ORGANISATION_SELECT,
	// Serial data out, three-state
	output logic      SERIAL_DATA_OUT,
	output logic      SERIAL_DATA_OUT_OE
);

	function automatic logic [4:0] addr_len(input logic wide);
		if (twe_pkg::ARRAY_KBITS == 1)
			addr_len = wide ? twe_pkg::ALEN_SMALL_X16 : twe_pkg::ALEN_SMALL_X8;
		else
			addr_len = wide ? twe_pkg::ALEN_BIG_X16 : twe_pkg::ALEN_BIG_X8;
	endfunction : addr_len

	function automatic logic [1:0] prefix_of(input logic [8:0] field, input logic [4:0] len);
		logic [8:0] sh;
		sh = field >> (len - 5'h02);
		prefix_of = sh[1:0];
	endfunction : prefix_of

	// Byte address of a field; bits past the variant's size are ignored
	function automatic logic [8:0] byte_of(input logic [8:0] field, input logic wide);
		logic [8:0] b;
		b = wide ? {field[7:0], 1'b0} : field;
		byte_of = b & twe_pkg::BYTE_MASK;
	endfunction : byte_of

	logic [3:0] pin_s;
	logic       cs, sclk, sdin, wide;
	logic       sclk_d_r, cs_d_r, sclk_rise, cs_rise, cs_fall;

	twe_sync twe_sync_inst (
		.clk      (CLOCK),
		.rst      (SYS_RST),
		.pins_in  ({CHIP_SELECT, SERIAL_CLOCK_IN, SERIAL_DATA_IN, ORGANISATION_SELECT}),
		.pins_out (pin_s)
	);

	assign cs   = pin_s[3];
	assign sclk = pin_s[2];
	assign sdin = pin_s[1];
	assign wide = pin_s[0];

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
			cs_d_r   <= cs;
		end
	end

	assign sclk_rise = sclk & ~sclk_d_r;
	assign cs_rise = cs & ~cs_d_r;
	assign cs_fall = ~cs & cs_d_r;

	twe_pkg::twe_state_t state_r;
	logic [4:0]  cnt_r;
	logic [1:0]  opc_r;
	logic [8:0]  addr_r;
	logic [15:0] data_r;
	logic        wen_r, prog_busy_r, stat_pend_r, all_r;
	logic [4:0]  alen, dlen;
	logic [8:0]  addr_full;
	logic [15:0] data_full;
	logic [1:0]  prefix_now;
	logic        start_seen, last_addr, last_data, read_last, prog_start;

	assign alen        = addr_len(wide);
	assign dlen        = wide ? twe_pkg::DLEN_X16 : twe_pkg::DLEN_X8;
	assign addr_full   = {addr_r[7:0], sdin};
	assign data_full   = {data_r[14:0], sdin};
	assign prefix_now  = prefix_of(addr_full, alen);

	// Busy device only answers status; start bits are ignored until the cycle ends
	assign start_seen = (state_r == twe_pkg::ST_IDLE || state_r == twe_pkg::ST_STATUS)
	                    && sclk_rise && sdin && !prog_busy_r;
	// Full field length is always counted, don't-care bits included
	assign last_addr  = state_r == twe_pkg::ST_ADDR && sclk_rise && cnt_r == alen - 5'h01;
	assign last_data  = state_r == twe_pkg::ST_DATA && sclk_rise && cnt_r == dlen - 5'h01;
	assign read_last  = last_addr && opc_r == twe_pkg::OPC_READ;
	assign prog_start = wen_r && ((last_addr && (opc_r == twe_pkg::OPC_ERASE ||
	                    (opc_r == twe_pkg::OPC_SPECIAL &&
	                     prefix_now == twe_pkg::SUB_ERASE_ALL))) || last_data);

	// Instruction sequencer
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			state_r <= twe_pkg::ST_IDLE;
			cnt_r   <= 5'h00;
			opc_r   <= 2'h0;
			addr_r  <= 9'h000;
			data_r  <= 16'h0000;
		end else if (!cs) begin
			state_r <= twe_pkg::ST_IDLE;
		end else begin
			case (state_r)
				twe_pkg::ST_IDLE, twe_pkg::ST_STATUS: begin
					if (start_seen) begin
						state_r <= twe_pkg::ST_OPC;
						cnt_r   <= 5'h00;
						addr_r  <= 9'h000;
						data_r  <= 16'h0000;
					end else if (cs_rise && stat_pend_r) begin
						state_r <= twe_pkg::ST_STATUS;
					end
				end
				twe_pkg::ST_OPC: begin
					if (sclk_rise) begin
						opc_r <= {opc_r[0], sdin};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == twe_pkg::OPC_LEN - 5'h01) begin
							state_r <= twe_pkg::ST_ADDR;
							cnt_r   <= 5'h00;
						end
					end
				end
				twe_pkg::ST_ADDR: begin
					if (sclk_rise) begin
						addr_r <= addr_full;
						cnt_r  <= cnt_r + 5'h01;
						if (last_addr) begin
							cnt_r <= 5'h00;
							if (opc_r == twe_pkg::OPC_READ)
								state_r <= twe_pkg::ST_READ;
							else if (opc_r == twe_pkg::OPC_WRITE ||
							         (opc_r == twe_pkg::OPC_SPECIAL &&
							          prefix_now == twe_pkg::SUB_WRITE_ALL))
								state_r <= twe_pkg::ST_DATA;
							else
								state_r <= twe_pkg::ST_HOLD;
						end
					end
				end
				twe_pkg::ST_DATA: begin
					if (sclk_rise) begin
						data_r <= data_full;
						cnt_r  <= cnt_r + 5'h01;
						if (last_data)
							state_r <= twe_pkg::ST_HOLD;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Write-enable latch
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			wen_r <= 1'b0;
		end else if (last_addr && opc_r == twe_pkg::OPC_SPECIAL) begin
			if (prefix_now == twe_pkg::SUB_WRITE_ENABLE)
				wen_r <= 1'b1;
			else if (prefix_now == twe_pkg::SUB_WRITE_DISABLE)
				wen_r <= 1'b0;
		end
	end

	// Program engine
	logic [15:0] timer_r;
	logic [8:0]  sweep_r;
	logic [7:0]  wr_word_r;
	logic [1:0]  wr_be_r;
	logic [15:0] wr_data_r;
	logic        mem_we;
	logic [8:0]  tgt_byte;
	logic [15:0] fill;

	assign tgt_byte = byte_of(last_data ? addr_r : addr_full, wide);
	assign fill     = wide ? data_full : {data_full[7:0], data_full[7:0]};
	assign mem_we   = prog_busy_r && (all_r ? !sweep_r[8] : sweep_r == twe_pkg::SWEEP_RST);

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			prog_busy_r <= 1'b0;
			timer_r     <= twe_pkg::TIMER_RST;
			sweep_r     <= twe_pkg::SWEEP_RST;
			all_r       <= 1'b0;
			wr_word_r   <= 8'h00;
			wr_be_r     <= 2'h0;
			wr_data_r   <= 16'h0000;
		end else if (prog_start) begin
			prog_busy_r <= 1'b1;
			timer_r     <= twe_pkg::TIMER_RST;
			sweep_r     <= twe_pkg::SWEEP_RST;
			wr_word_r   <= tgt_byte[8:1];
			wr_be_r     <= wide ? 2'h3 : (tgt_byte[0] ? 2'h1 : 2'h2);
			if (last_data) begin
				all_r     <= opc_r == twe_pkg::OPC_SPECIAL;
				wr_data_r <= fill;
			end else begin
				all_r     <= opc_r == twe_pkg::OPC_SPECIAL;
				wr_data_r <= twe_pkg::ERASED_WORD;
			end
		end else if (prog_busy_r) begin
			if (!sweep_r[8])
				sweep_r <= sweep_r + 9'h001;
			timer_r <= timer_r + 16'h0001;
			if (timer_r == 16'(PROG_CYCLES - 1))
				prog_busy_r <= 1'b0;
		end
	end

	// Status stays pending until the host has seen ready or starts anew
	always_ff @(posedge CLOCK) begin
		if (SYS_RST)
			stat_pend_r <= 1'b0;
		else if (prog_start)
			stat_pend_r <= 1'b1;
		else if (start_seen || (cs_fall && state_r == twe_pkg::ST_STATUS && !prog_busy_r))
			stat_pend_r <= 1'b0;
	end

	// Read path: one word fetched ahead of the bits shifted out
	logic [8:0]  rd_addr_r;
	logic [15:0] rd_word, rd_sh_r;
	logic [4:0]  rd_cnt_r;
	logic        rd_req_r, rd_load_r;

	twe_mem twe_mem_inst (
		.clk   (CLOCK),
		.we    (mem_we),
		.be    (all_r ? 2'h3 : wr_be_r),
		.waddr (all_r ? sweep_r[7:0] : wr_word_r),
		.wdata (wr_data_r),
		.raddr (rd_addr_r[8:1]),
		.rdata (rd_word)
	);

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rd_addr_r <= 9'h000;
			rd_sh_r   <= 16'h0000;
			rd_cnt_r  <= 5'h00;
			rd_req_r  <= 1'b0;
			rd_load_r <= 1'b0;
		end else begin
			rd_req_r  <= 1'b0;
			rd_load_r <= rd_req_r;
			if (rd_load_r)
				rd_sh_r <= wide ? rd_word :
				           {(rd_addr_r[0] ? rd_word[7:0] : rd_word[15:8]), 8'h00};
			if (read_last) begin
				rd_addr_r <= byte_of(addr_full, wide);
				rd_cnt_r  <= 5'h00;
				rd_req_r  <= 1'b1;
			end else if (state_r == twe_pkg::ST_READ && cs && sclk_rise) begin
				rd_sh_r  <= {rd_sh_r[14:0], 1'b0};
				rd_cnt_r <= rd_cnt_r + 5'h01;
				if (rd_cnt_r == dlen - 5'h01) begin
					rd_cnt_r  <= 5'h00;
					rd_addr_r <= (rd_addr_r + (wide ? 9'h002 : 9'h001)) & twe_pkg::BYTE_MASK;
					rd_req_r  <= 1'b1;
				end
			end
		end
	end

	// Serial output pin
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !cs) begin
			SERIAL_DATA_OUT    <= 1'b0;
			SERIAL_DATA_OUT_OE <= 1'b0;
		end else if (state_r == twe_pkg::ST_STATUS) begin
			SERIAL_DATA_OUT    <= !prog_busy_r;
			SERIAL_DATA_OUT_OE <= 1'b1;
		end else if (read_last) begin
			SERIAL_DATA_OUT    <= 1'b0;
			SERIAL_DATA_OUT_OE <= 1'b1;
		end else if (state_r == twe_pkg::ST_READ) begin
			if (sclk_rise)
				SERIAL_DATA_OUT <= rd_sh_r[15];
		end else begin
			SERIAL_DATA_OUT    <= 1'b0;
			SERIAL_DATA_OUT_OE <= 1'b0;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	deselect_float_a: assert property (!cs |=> !SERIAL_DATA_OUT_OE)
		else $error("output driven while deselected");
	wen_clear_a: assert property (disable iff (1'b0) SYS_RST |=> !wen_r)
		else $error("enable latch not cleared by reset");
	gated_write_a: assert property (prog_start |-> wen_r && $past(wen_r))
		else $error("program cycle started without enable");
	dummy_zero_a: assert property (read_last && cs |=> SERIAL_DATA_OUT_OE && !SERIAL_DATA_OUT)
		else $error("no dummy zero before read data");
	status_busy_a: assert property (state_r == twe_pkg::ST_STATUS && cs && prog_busy_r
		|=> SERIAL_DATA_OUT_OE && !SERIAL_DATA_OUT)
		else $error("status not low while busy");
	cycle_end_a: assert property (prog_busy_r && timer_r == 16'(PROG_CYCLES - 1)
		|=> !prog_busy_r ##1 state_r != twe_pkg::ST_STATUS || !prog_busy_r)
		else $error("program cycle did not end");
	enable_set_a: assert property (last_addr && opc_r == twe_pkg::OPC_SPECIAL
		&& prefix_now == twe_pkg::SUB_WRITE_ENABLE |=> wen_r [*2])
		else $error("enable instruction ignored");
	disable_clr_a: assert property (last_addr && opc_r == twe_pkg::OPC_SPECIAL
		&& prefix_now == twe_pkg::SUB_WRITE_DISABLE |=> !wen_r)
		else $error("disable instruction ignored");
	read_any_a: assert property (read_last && cs |=> state_r == twe_pkg::ST_READ
		|| !cs)
		else $error("read refused");
	erase_ones_a: assert property (prog_start && !last_data |=> wr_data_r == twe_pkg::ERASED_WORD)
		else $error("erase pattern not all ones");
	auto_start_a: assert property (last_data && wen_r && cs |=> prog_busy_r)
		else $error("write cycle did not start");
	sweep_all_a: assert property (prog_busy_r && all_r && timer_r == 16'(PROG_CYCLES - 1)
		|-> sweep_r[8])
		else $error("array sweep not finished at cycle end");
	busy_blocks_a: assert property (prog_busy_r |=> state_r != twe_pkg::ST_OPC)
		else $error("instruction accepted while busy");

	read_seen_c: cover property (read_last ##[1:300] rd_load_r);
	write_seen_c: cover property (last_data && wen_r ##1 prog_busy_r);
	status_seen_c: cover property (state_r == twe_pkg::ST_STATUS && !prog_busy_r
		&& SERIAL_DATA_OUT);

endmodule : twe_cmd_port

`default_nettype wire

// [hdl/twe_pkg.sv]
// Constants, encodings and timing for the three-wire EEPROM command port.
// Assumes a 10 MHz system clock that samples all serial pins.
`default_nettype none

package twe_pkg;

	// Array size variant in kilobits: 1, 2 or 4
	localparam int unsigned ARRAY_KBITS = 4;

	// Storage geometry, always built at the largest size
	localparam int unsigned DATA_W  = 16;
	localparam int unsigned WORDS   = 256;
	localparam int unsigned WORD_AW = 8;
	localparam int unsigned FIELD_W = 9;
	localparam int unsigned PIN_W   = 4;

	// Address, data and opcode field lengths per variant and organisation
	localparam logic [4:0] ALEN_BIG_X8   = 5'h09;
	localparam logic [4:0] ALEN_BIG_X16  = 5'h08;
	localparam logic [4:0] ALEN_SMALL_X8  = 5'h07;
	localparam logic [4:0] ALEN_SMALL_X16 = 5'h06;
	localparam logic [4:0] DLEN_X8  = 5'h08;
	localparam logic [4:0] DLEN_X16 = 5'h10;
	localparam logic [4:0] OPC_LEN  = 5'h02;

	// Byte addresses reachable in each variant; higher bits alias
	localparam logic [8:0] BYTE_MASK = (ARRAY_KBITS == 4) ? 9'h1ff :
	                                   (ARRAY_KBITS == 2) ? 9'h0ff : 9'h07f;

	// Opcodes and special-instruction prefixes
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] SUB_WRITE_DISABLE = 2'h0;
	localparam logic [1:0] SUB_WRITE_ALL     = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL     = 2'h2;
	localparam logic [1:0] SUB_WRITE_ENABLE  = 2'h3;

	// Self-timed program cycle
	localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
	localparam int unsigned PROG_TIME_MS = 3;
	localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);

	// Erase pattern and reset values
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [8:0]  SWEEP_RST   = 9'h000;
	localparam logic [15:0] TIMER_RST   = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_OPC    = 3'b001,
		ST_ADDR   = 3'b010,
		ST_DATA   = 3'b011,
		ST_READ   = 3'b100,
		ST_HOLD   = 3'b101,
		ST_STATUS = 3'b110
	} twe_state_t;

endpackage : twe_pkg

`default_nettype wire

// [hdl/twe_sync.sv]
// Two-stage synchroniser for the serial pins.
// Assumes the pins are asynchronous to CLOCK; only the second stage is read.
`default_nettype none

module twe_sync (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Pins in, synchronised levels out
	input  wire logic [twe_pkg::PIN_W-1:0] pins_in,
	output logic      [twe_pkg::PIN_W-1:0] pins_out
);

	logic [twe_pkg::PIN_W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r   <= '0;
			pins_out <= '0;
		end else begin
			meta_r   <= pins_in;
			pins_out <= meta_r;
		end
	end

endmodule : twe_sync

`default_nettype wire

// [hdl/twe_mem.sv]
// Storage array: 256 words of 16 bits with byte-lane writes.
// Assumes one write port and one read port; read data come from a register.
`default_nettype none

module twe_mem (
	// Clock
	input  wire logic                        clk,
	// Write port
	input  wire logic                        we,
	input  wire logic [1:0]                  be,
	input  wire logic [twe_pkg::WORD_AW-1:0] waddr,
	input  wire logic [twe_pkg::DATA_W-1:0]  wdata,
	// Read port
	input  wire logic [twe_pkg::WORD_AW-1:0] raddr,
	output logic      [twe_pkg::DATA_W-1:0]  rdata
);

	logic [twe_pkg::DATA_W-1:0] mem [twe_pkg::WORDS];

	always_ff @(posedge clk) begin
		if (we && be[1])
			mem[waddr][15:8] <= wdata[15:8];
		if (we && be[0])
			mem[waddr][7:0] <= wdata[7:0];
	end

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end

endmodule : twe_mem

`default_nettype wire

// [bench/twe_host.sv]
// Host model: drives chip select, serial clock and data, samples read data.
// Assumes the device CLOCK; every pin change lands on its falling edge.
`default_nettype none

module twe_host (
	// Clock
	input  wire logic clk,
	// Link pins
	output var logic  cs,
	output var logic  sclk,
	output var logic  sdin,
	input  wire logic dout,
	input  wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cs = 1'b0;
		sclk = 1'b0;
		sdin = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk

	// Six clocks per half period, well above the pin sync latency
	task automatic shift(input logic [63:0] v, input int n, output logic [63:0] got);
		got = '0;
		cs = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			sdin = v[i];
			wait_clk(6);
			sclk = 1'b1;
			wait_clk(6);
			got = {got[62:0], dout};
			sclk = 1'b0;
		end
	endtask : shift

	// Released data line shows the inverse so a stale bit is never trusted
	task automatic deselect;
		cs = 1'b0;
		sdin = ~sdin;
		wait_clk(4);
	endtask : deselect

	task automatic poll(output logic oe, output logic d);
		cs = 1'b1;
		wait_clk(8);
		oe = dout_oe;
		d = dout;
		deselect();
	endtask : poll
endmodule : twe_host

`default_nettype wire

// [bench/twe_cmd_port_tb.sv]
// Testbench for the command port; one task per scenario, host model on the link.
// Assumes a shortened program cycle and the host model of twe_host.sv.
`default_nettype none

module twe_cmd_port_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned PROG = 300;

	logic        clock;
	logic        sys_rst;
	logic        wide_mode;
	logic        cs;
	logic        sclk;
	logic        sdin;
	logic        dout;
	logic        dout_oe;
	int          errors;
	int          total_checks;
	logic [63:0] got;

	twe_cmd_port #(.PROG_CYCLES(PROG)) twe_cmd_port_inst (
		.CLOCK(clock), .SYS_RST(sys_rst), .CHIP_SELECT(cs), .SERIAL_CLOCK_IN(sclk),
		.SERIAL_DATA_IN(sdin), .ORGANISATION_SELECT(wide_mode), .SERIAL_DATA_OUT(dout),
		.SERIAL_DATA_OUT_OE(dout_oe)
	);

	twe_host twe_host_inst (
		.clk(clock), .cs(cs), .sclk(sclk), .sdin(sdin), .dout(dout), .dout_oe(dout_oe)
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			errors++;
		end
	endtask : check

	task automatic run(input logic [63:0] v, input int n);
		twe_host_inst.shift(v, n, got);
		twe_host_inst.deselect();
	endtask : run

	task automatic spec(input logic [1:0] sub, input logic [15:0] d, input logic with_data);
		if (with_data) begin
			run((64'({1'b1, twe_pkg::OPC_SPECIAL, sub, 6'h00}) << 16) | 64'(d), 27);
		end else begin
			run(64'({1'b1, twe_pkg::OPC_SPECIAL, sub, 6'h00}), 11);
		end
	endtask : spec

	// Ready is only shown when a driven line says so
	task automatic poll(input logic [1:0] exp, input string what);
		logic o;
		logic d;
		twe_host_inst.poll(o, d);
		check(what, 32'(exp), 32'({o, o & d}));
	endtask : poll

	task automatic prog_done;
		poll(2'b10, "busy status");
		repeat (PROG + 100) @(negedge clock);
		poll(2'b11, "ready status");
		poll(2'b00, "status after standby");
	endtask : prog_done

	task automatic rd16(input logic [7:0] a, input int k);
		twe_host_inst.shift(64'({1'b1, twe_pkg::OPC_READ, a}) << (16 * k), 11 + 16 * k, got);
		twe_host_inst.deselect();
		check("read dummy bit", 32'h0, 32'(got[16 * k]));
	endtask : rd16

	task automatic t_locked;
		run(64'({1'b1, twe_pkg::OPC_WRITE, 8'h03, 16'h0000}), 27);
		poll(2'b00, "no cycle while locked");
		$display("test locked done");
	endtask : t_locked

	task automatic t_write;
		spec(twe_pkg::SUB_WRITE_ENABLE, 16'h0000, 1'b0);
		run(64'({1'b1, twe_pkg::OPC_WRITE, 8'h03, 16'ha5c3}), 27);
		prog_done();
		rd16(8'h03, 1);
		check("word 3", 32'h0000a5c3, 32'(got[15:0]));
		$display("test write done");
	endtask : t_write

	task automatic t_bytes;
		wide_mode = 1'b0;
		twe_host_inst.shift(64'({2'b00, 1'b1, twe_pkg::OPC_READ, 9'h006}) << 16, 30, got);
		twe_host_inst.deselect();
		check("bytes 6 and 7", 32'h0000a5c3, 32'(got[15:0]));
		wide_mode = 1'b1;
		$display("test bytes done");
	endtask : t_bytes

	task automatic t_erase;
		run(64'({1'b1, twe_pkg::OPC_ERASE, 8'h03}), 11);
		prog_done();
		rd16(8'h03, 1);
		check("erased word 3", 32'h0000ffff, 32'(got[15:0]));
		$display("test erase done");
	endtask : t_erase

	task automatic t_all;
		spec(twe_pkg::SUB_WRITE_ALL, 16'h1234, 1'b1);
		prog_done();
		rd16(8'hff, 2);
		check("words 255 and 0", 32'h12341234, got[31:0]);
		spec(twe_pkg::SUB_ERASE_ALL, 16'h0000, 1'b0);
		prog_done();
		rd16(8'h07, 1);
		check("word 7 after erase all", 32'h0000ffff, 32'(got[15:0]));
		$display("test all done");
	endtask : t_all

	task automatic t_disable;
		spec(twe_pkg::SUB_WRITE_DISABLE, 16'h0000, 1'b0);
		run(64'({1'b1, twe_pkg::OPC_WRITE, 8'h07, 16'h0000}), 27);
		poll(2'b00, "no cycle when disabled");
		rd16(8'h07, 1);
		check("word 7 kept", 32'h0000ffff, 32'(got[15:0]));
		$display("test disable done");
	endtask : t_disable

	task automatic t_abort;
		twe_host_inst.shift(64'({1'b1, twe_pkg::OPC_READ, 8'h07}) << 4, 15, got);
		check("driving mid read", 32'h1, 32'(dout_oe));
		twe_host_inst.deselect();
		repeat (2) @(negedge clock);
		check("floated after deselect", 32'h0, 32'(dout_oe));
		rd16(8'h07, 1);
		check("read after abort", 32'h0000ffff, 32'(got[15:0]));
		$display("test abort done");
	endtask : t_abort

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	// About 6350 clocks expected; over nine times that is a hang
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		close_out();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		wide_mode = 1'b1;
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		repeat (4) @(negedge clock);
		t_locked();
		t_write();
		t_bytes();
		t_erase();
		t_all();
		t_disable();
		t_abort();
		close_out();
	end
endmodule : twe_cmd_port_tb

`default_nettype wire
